// *** verilog/ivp_pkg.sv ***
// package: offsets, field positions, reset values and source table of the vector/priority map
package ivp_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_VBASE = 8'h04;
  localparam logic [7:0] OFS_PRIO_A = 8'h08;
  localparam logic [7:0] OFS_PRIO_B = 8'h0C;
  localparam logic [7:0] OFS_PRIO_C = 8'h10;
  localparam logic [7:0] OFS_DMA0_VEC = 8'h14;
  localparam logic [7:0] OFS_DMA1_VEC = 8'h18;
  localparam logic [7:0] OFS_WDT_VEC = 8'h1C;
  localparam logic [7:0] OFS_ETH_VEC = 8'h20;
  localparam logic [7:0] OFS_RSV_SLOT = 8'h24;
  localparam logic [7:0] OFS_FRT_VEC_C = 8'h28;
  localparam logic [7:0] OFS_FRT_VEC_D = 8'h2C;
  localparam logic [7:0] OFS_ETH_STAT = 8'h30;
  localparam logic [7:0] OFS_ETH_PERM = 8'h34;
  localparam logic [7:0] OFS_MAC_PERM = 8'h38;
  localparam logic [7:0] OFS_EVT_STAT = 8'h3C;
  localparam logic [7:0] OFS_EVT_CLR = 8'h40;
  localparam logic [7:0] OFS_EVT_EN = 8'h44;
  // control fields
  localparam int CTRL_MODE_BIT = 0;
  localparam int CTRL_EXTV_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [15:0] PRIO_RESET = 16'h0000;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [31:0] VBASE_RESET = 32'h0000_0000;
  // vector field positions inside a vector register
  localparam int VEC_HI_LSB = 8;
  localparam int VEC_LO_LSB = 0;
  // ethernet dma status sources
  localparam int ETH_SRC_N = 19;
  localparam int ETH_SUM_BIT = 18;
  localparam int MAC_SRC_N = 3;
  // event status bits
  localparam int EVT_N = 3;
  localparam int EVT_NMI = 0;
  localparam int EVT_UBRK = 1;
  localparam int EVT_ETH = 2;
  // fixed vectors and levels
  localparam logic [6:0] VEC_NMI = 7'h0B;
  localparam logic [6:0] VEC_UBRK = 7'h0C;
  localparam logic [6:0] VEC_DBG = 7'h0D;
  localparam logic [6:0] VEC_XIRQ0 = 7'h40;
  localparam logic [4:0] LVL_NMI = 5'h10;
  localparam logic [4:0] LVL_DBG = 5'h0F;
  // source slots, highest default order first
  localparam int SRC_N = 15;
  localparam int S_NMI = 0;
  localparam int S_UBRK = 1;
  localparam int S_DBG = 2;
  localparam int S_XIRQ = 3;
  localparam int S_DMA0 = 7;
  localparam int S_DMA1 = 8;
  localparam int S_ITI = 9;
  localparam int S_CMI = 10;
  localparam int S_ETH = 11;
  localparam int S_FRT = 12;
  // request towards the cpu core
  typedef struct packed {
    logic valid;
    logic [4:0] level;
    logic [6:0] vector;
  } ivp_cpu_req_t;
  // on-chip peripheral request lines
  typedef struct packed {
    logic [1:0] dma_end;
    logic interval_timer_request;
    logic refresh_compare_match_request;
    logic [2:0] frt;
  } ivp_periph_t;
endpackage : ivp_pkg

// *** verilog/ivp_ctrl.sv ***
// interrupt vector and priority map: arbiter, vector/priority registers, ethernet request merge
//
// What this block does
// (R1) with external fetch on, a winning external pin takes an outside vector 0-127
// (R2) each on-chip source takes its vector from a software vector register field
// (R3) mode bit picks encoded level lines 1-15 or four separate request pins
// (R4) second ethernet vector slot is reserved: reads zero, writes ignored
// (R5) ethernet request is OR of status bits whose permit bits are set
// (R6) three mac status bits fold into one summary bit, at most 21 sources
// (R7) nmi vector 11 level 16, user break 12, debug 13 level 15, that order
// (R8) refresh match uses watchdog vector bits 6-0, interval timer bits 14-8
// (R9) four request pins use vectors 64-67, levels from priority register c fields
// (R10) ties go by fixed slot order; vector address is base plus four times vector
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module ivp_ctrl #(
  parameter logic [4:0] UBRK_LEVEL = 5'h0F
) (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic nmi_in,
  input wire logic ubrk_in,
  input wire logic dbg_in,
  input wire logic [3:0] ext_req_in,
  input wire logic [6:0] ext_vec_in,
  input wire ivp_pkg::ivp_periph_t periph_in,
  input wire logic [17:0] eth_set_in,
  input wire logic [2:0] mac_status_in,
  input wire logic [3:0] cpu_mask_in,
  output ivp_pkg::ivp_cpu_req_t cpu_req_out,
  output logic [31:0] vec_addr_out,
  output logic eth_req_out,
  output logic int_out
);
  // elaboration check: no maskable source may sit above the non-maskable level
  if (UBRK_LEVEL > 5'h10) begin : g_bad_level
    $error("user break level above 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [1:0] ctrl_r;
  logic [31:0] vbase_r;
  logic [15:0] prio_a_r, prio_b_r, prio_c_r;
  logic [15:0] dma0_vec_r, dma1_vec_r, wdt_vec_r, eth_vec_r, frt_c_r, frt_d_r;
  logic [ivp_pkg::ETH_SRC_N-1:0] eth_stat_r, eth_stat_nxt, eth_perm_r;
  logic [ivp_pkg::MAC_SRC_N-1:0] mac_perm_r;
  logic [ivp_pkg::EVT_N-1:0] evt_stat_r, evt_stat_nxt, evt_en_r, evt_set;
  logic nmi_d_r, ubrk_d_r, eth_d_r;

  // address decode
  wire logic wr_ctrl = wr_in && (addr_in == ivp_pkg::OFS_CTRL);
  wire logic wr_vbase = wr_in && (addr_in == ivp_pkg::OFS_VBASE);
  wire logic wr_pa = wr_in && (addr_in == ivp_pkg::OFS_PRIO_A);
  wire logic wr_pb = wr_in && (addr_in == ivp_pkg::OFS_PRIO_B);
  wire logic wr_pc = wr_in && (addr_in == ivp_pkg::OFS_PRIO_C);
  wire logic wr_d0 = wr_in && (addr_in == ivp_pkg::OFS_DMA0_VEC);
  wire logic wr_d1 = wr_in && (addr_in == ivp_pkg::OFS_DMA1_VEC);
  wire logic wr_wdt = wr_in && (addr_in == ivp_pkg::OFS_WDT_VEC);
  wire logic wr_eth = wr_in && (addr_in == ivp_pkg::OFS_ETH_VEC);
  wire logic wr_fc = wr_in && (addr_in == ivp_pkg::OFS_FRT_VEC_C);
  wire logic wr_fd = wr_in && (addr_in == ivp_pkg::OFS_FRT_VEC_D);
  wire logic wr_estat = wr_in && (addr_in == ivp_pkg::OFS_ETH_STAT);
  wire logic wr_eperm = wr_in && (addr_in == ivp_pkg::OFS_ETH_PERM);
  wire logic wr_mperm = wr_in && (addr_in == ivp_pkg::OFS_MAC_PERM);
  wire logic wr_eclr = wr_in && (addr_in == ivp_pkg::OFS_EVT_CLR);
  wire logic wr_een = wr_in && (addr_in == ivp_pkg::OFS_EVT_EN);
  // vector registers keep only the two 7-bit fields
  wire logic [15:0] vec_wmask = 16'h7F7F;
  wire logic [15:0] vec_wdata = wdata_in[15:0] & vec_wmask;

  // software-written configuration
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_r <= ivp_pkg::CTRL_RESET;
      vbase_r <= ivp_pkg::VBASE_RESET;
      prio_a_r <= ivp_pkg::PRIO_RESET;
      prio_b_r <= ivp_pkg::PRIO_RESET;
      prio_c_r <= ivp_pkg::PRIO_RESET; // R9
      dma0_vec_r <= ivp_pkg::VEC_RESET;
      dma1_vec_r <= ivp_pkg::VEC_RESET;
      wdt_vec_r <= ivp_pkg::VEC_RESET;
      eth_vec_r <= ivp_pkg::VEC_RESET;
      frt_c_r <= ivp_pkg::VEC_RESET;
      frt_d_r <= ivp_pkg::VEC_RESET;
      eth_perm_r <= '0;
      mac_perm_r <= '0;
      evt_en_r <= '0;
    end else begin
      if (wr_ctrl) ctrl_r <= wdata_in[1:0];
      if (wr_vbase) vbase_r <= wdata_in;
      if (wr_pa) prio_a_r <= wdata_in[15:0];
      if (wr_pb) prio_b_r <= wdata_in[15:0];
      if (wr_pc) prio_c_r <= wdata_in[15:0];
      if (wr_d0) dma0_vec_r <= vec_wdata; // R2
      if (wr_d1) dma1_vec_r <= vec_wdata;
      if (wr_wdt) wdt_vec_r <= vec_wdata;
      if (wr_eth) eth_vec_r <= vec_wdata;
      if (wr_fc) frt_c_r <= vec_wdata;
      if (wr_fd) frt_d_r <= vec_wdata;
      if (wr_eperm) eth_perm_r <= wdata_in[ivp_pkg::ETH_SRC_N-1:0];
      if (wr_mperm) mac_perm_r <= wdata_in[ivp_pkg::MAC_SRC_N-1:0];
      if (wr_een) evt_en_r <= wdata_in[ivp_pkg::EVT_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ethernet dma status: write-one-to-clear, a set in the same cycle wins
  wire logic mac_sum = |(mac_status_in & mac_perm_r); // R6
  wire logic [ivp_pkg::ETH_SRC_N-1:0] eth_set = {mac_sum, eth_set_in}; // R6
  wire logic [ivp_pkg::ETH_SRC_N-1:0] eth_clr =
    wr_estat ? wdata_in[ivp_pkg::ETH_SRC_N-1:0] : '0;
  assign eth_stat_nxt = (eth_stat_r & ~eth_clr) | eth_set;
  wire logic eth_comb = |(eth_stat_r & eth_perm_r); // R5

  // event flags for the summary interrupt, rising edges only
  assign evt_set = {eth_comb && !eth_d_r, ubrk_in && !ubrk_d_r, nmi_in && !nmi_d_r};
  wire logic [ivp_pkg::EVT_N-1:0] evt_clr = wr_eclr ? wdata_in[ivp_pkg::EVT_N-1:0] : '0;
  assign evt_stat_nxt = (evt_stat_r & ~evt_clr) | evt_set;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      eth_stat_r <= '0;
      evt_stat_r <= '0;
      nmi_d_r <= 1'b0;
      ubrk_d_r <= 1'b0;
      eth_d_r <= 1'b0;
    end else begin
      eth_stat_r <= eth_stat_nxt;
      evt_stat_r <= evt_stat_nxt;
      nmi_d_r <= nmi_in;
      ubrk_d_r <= ubrk_in;
      eth_d_r <= eth_comb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-slot request, level and vector
  logic src_req [ivp_pkg::SRC_N];
  logic [4:0] src_lvl [ivp_pkg::SRC_N];
  logic [6:0] src_vec [ivp_pkg::SRC_N];
  wire logic irq_mode = ctrl_r[ivp_pkg::CTRL_MODE_BIT]; // R3
  wire logic ext_fetch = ctrl_r[ivp_pkg::CTRL_EXTV_BIT];

  // fixed sources
  assign src_req[ivp_pkg::S_NMI] = nmi_in; // R7
  assign src_lvl[ivp_pkg::S_NMI] = ivp_pkg::LVL_NMI;
  assign src_vec[ivp_pkg::S_NMI] = ivp_pkg::VEC_NMI;
  assign src_req[ivp_pkg::S_UBRK] = ubrk_in;
  assign src_lvl[ivp_pkg::S_UBRK] = UBRK_LEVEL;
  assign src_vec[ivp_pkg::S_UBRK] = ivp_pkg::VEC_UBRK;
  assign src_req[ivp_pkg::S_DBG] = dbg_in;
  assign src_lvl[ivp_pkg::S_DBG] = ivp_pkg::LVL_DBG;
  assign src_vec[ivp_pkg::S_DBG] = ivp_pkg::VEC_DBG;

  // external pins: separate requests, or slot 0 carries the encoded level
  for (genvar j = 0; j < 4; j++) begin : g_xirq
    wire logic [3:0] pc_fld = prio_c_r[15-4*j -: 4]; // R9
    wire logic [3:0] lvl_sel = irq_mode ? pc_fld : ((j == 0) ? ext_req_in : 4'h0); // R3
    wire logic [6:0] auto_vec = irq_mode ? ivp_pkg::VEC_XIRQ0 + 7'(j)
                                         : ivp_pkg::VEC_XIRQ0 + 7'(ext_req_in[3:1]);
    assign src_req[ivp_pkg::S_XIRQ+j] = irq_mode ? ext_req_in[j] : (j == 0); // R3
    assign src_lvl[ivp_pkg::S_XIRQ+j] = {1'b0, lvl_sel};
    assign src_vec[ivp_pkg::S_XIRQ+j] = ext_fetch ? ext_vec_in : auto_vec; // R1
  end

  // on-chip sources take software vectors; shared fields ordered by slot
  assign src_req[ivp_pkg::S_DMA0] = periph_in.dma_end[0];
  assign src_lvl[ivp_pkg::S_DMA0] = {1'b0, prio_a_r[11:8]};
  assign src_vec[ivp_pkg::S_DMA0] = dma0_vec_r[ivp_pkg::VEC_LO_LSB +: 7]; // R2
  assign src_req[ivp_pkg::S_DMA1] = periph_in.dma_end[1];
  assign src_lvl[ivp_pkg::S_DMA1] = {1'b0, prio_a_r[11:8]};
  assign src_vec[ivp_pkg::S_DMA1] = dma1_vec_r[ivp_pkg::VEC_LO_LSB +: 7];
  assign src_req[ivp_pkg::S_ITI] = periph_in.interval_timer_request;
  assign src_lvl[ivp_pkg::S_ITI] = {1'b0, prio_a_r[7:4]};
  assign src_vec[ivp_pkg::S_ITI] = wdt_vec_r[ivp_pkg::VEC_HI_LSB +: 7]; // R8
  assign src_req[ivp_pkg::S_CMI] = periph_in.refresh_compare_match_request;
  assign src_lvl[ivp_pkg::S_CMI] = {1'b0, prio_a_r[7:4]};
  assign src_vec[ivp_pkg::S_CMI] = wdt_vec_r[ivp_pkg::VEC_LO_LSB +: 7]; // R8
  assign src_req[ivp_pkg::S_ETH] = eth_comb; // R5
  assign src_lvl[ivp_pkg::S_ETH] = {1'b0, prio_b_r[15:12]};
  assign src_vec[ivp_pkg::S_ETH] = eth_vec_r[ivp_pkg::VEC_HI_LSB +: 7];
  assign src_req[ivp_pkg::S_FRT] = periph_in.frt[0];
  assign src_lvl[ivp_pkg::S_FRT] = {1'b0, prio_b_r[11:8]};
  assign src_vec[ivp_pkg::S_FRT] = frt_c_r[ivp_pkg::VEC_HI_LSB +: 7];
  assign src_req[ivp_pkg::S_FRT+1] = periph_in.frt[1];
  assign src_lvl[ivp_pkg::S_FRT+1] = {1'b0, prio_b_r[11:8]};
  assign src_vec[ivp_pkg::S_FRT+1] = frt_c_r[ivp_pkg::VEC_LO_LSB +: 7];
  assign src_req[ivp_pkg::S_FRT+2] = periph_in.frt[2];
  assign src_lvl[ivp_pkg::S_FRT+2] = {1'b0, prio_b_r[11:8]};
  assign src_vec[ivp_pkg::S_FRT+2] = frt_d_r[ivp_pkg::VEC_HI_LSB +: 7];

  ////////////////////////////////////////////////////////////////////////////
  // arbitration: strictly higher level replaces, so earlier slots win ties
  logic [4:0] win_lvl;
  logic [6:0] win_vec;
  logic win_found;
  logic [3:0] win_idx;
  always_comb begin
    win_lvl = {1'b0, cpu_mask_in};
    win_vec = 7'h00;
    win_found = 1'b0;
    win_idx = 4'h0;
    for (int i = 0; i < ivp_pkg::SRC_N; i++) begin
      if (src_req[i] && (src_lvl[i] > win_lvl)) begin // R10
        win_lvl = src_lvl[i];
        win_vec = src_vec[i];
        win_found = 1'b1;
        win_idx = 4'(i);
      end
    end
  end
  wire logic [31:0] win_addr = vbase_r + {23'h0, win_vec, 2'b00}; // R10

  // read mux; reserved slot and unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    case (addr_in)
      ivp_pkg::OFS_CTRL: rd_mux = {30'h0, ctrl_r};
      ivp_pkg::OFS_VBASE: rd_mux = vbase_r;
      ivp_pkg::OFS_PRIO_A: rd_mux = {16'h0, prio_a_r};
      ivp_pkg::OFS_PRIO_B: rd_mux = {16'h0, prio_b_r};
      ivp_pkg::OFS_PRIO_C: rd_mux = {16'h0, prio_c_r};
      ivp_pkg::OFS_DMA0_VEC: rd_mux = {16'h0, dma0_vec_r};
      ivp_pkg::OFS_DMA1_VEC: rd_mux = {16'h0, dma1_vec_r};
      ivp_pkg::OFS_WDT_VEC: rd_mux = {16'h0, wdt_vec_r};
      ivp_pkg::OFS_ETH_VEC: rd_mux = {16'h0, eth_vec_r};
      ivp_pkg::OFS_RSV_SLOT: rd_mux = 32'h0000_0000; // R4
      ivp_pkg::OFS_FRT_VEC_C: rd_mux = {16'h0, frt_c_r};
      ivp_pkg::OFS_FRT_VEC_D: rd_mux = {16'h0, frt_d_r};
      ivp_pkg::OFS_ETH_STAT: rd_mux = {13'h0, eth_stat_r};
      ivp_pkg::OFS_ETH_PERM: rd_mux = {13'h0, eth_perm_r};
      ivp_pkg::OFS_MAC_PERM: rd_mux = {29'h0, mac_perm_r};
      ivp_pkg::OFS_EVT_STAT: rd_mux = {29'h0, evt_stat_r};
      ivp_pkg::OFS_EVT_EN: rd_mux = {29'h0, evt_en_r};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // registered outputs, one cycle behind their cause
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cpu_req_out <= '0;
      vec_addr_out <= 32'h0000_0000;
      eth_req_out <= 1'b0;
      int_out <= 1'b0;
      rdata_out <= 32'h0000_0000;
    end else begin
      cpu_req_out <= '{valid: win_found, level: win_lvl, vector: win_vec};
      vec_addr_out <= win_addr;
      eth_req_out <= eth_comb;
      int_out <= |(evt_stat_nxt & evt_en_r);
      rdata_out <= rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_nmi_fixed: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R7
    nmi_in |=> cpu_req_out.valid && cpu_req_out.level == 5'h10 && cpu_req_out.vector == 7'h0B)
    else $error("nmi not presented at vector 11 level 16");
  a_debug_fixed: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R7
    dbg_in && !nmi_in && !ubrk_in && cpu_mask_in != 4'hF
    |=> cpu_req_out.level == 5'h0F && cpu_req_out.vector == 7'h0D)
    else $error("debug port not presented at vector 13 level 15");
  a_vec_address: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R10
    cpu_req_out.valid |-> vec_addr_out == $past(vbase_r) + {23'h0, cpu_req_out.vector, 2'b00})
    else $error("vector address is not base plus four times vector");
  a_wdt_share: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R8
    win_found && win_idx == 4'(ivp_pkg::S_CMI) |=> cpu_req_out.vector == $past(wdt_vec_r[6:0]))
    else $error("refresh match vector not from low watchdog field");
  a_share_order: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R10
    periph_in.interval_timer_request && periph_in.refresh_compare_match_request && win_found && win_idx == 4'(ivp_pkg::S_CMI) |-> 1'b0)
    else $error("refresh match beat interval timer on a shared field");
  a_periph_vec: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R2
    win_found && win_idx == 4'(ivp_pkg::S_DMA0) |=> cpu_req_out.vector == $past(dma0_vec_r[6:0]))
    else $error("dma vector not taken from its register");
  a_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R4
    rd_in && addr_in == ivp_pkg::OFS_RSV_SLOT |=> rdata_out == 32'h0000_0000)
    else $error("reserved vector slot read nonzero");
  a_eth_permit: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R5
    eth_perm_r == '0 |=> !eth_req_out)
    else $error("ethernet request without any permit bit");
  a_mac_summary: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R6
    |(mac_status_in & mac_perm_r) |=> eth_stat_r[ivp_pkg::ETH_SUM_BIT])
    else $error("mac status not folded into summary bit");
  a_ext_vector: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R1
    ext_fetch && win_found && win_idx == 4'(ivp_pkg::S_XIRQ)
    |=> cpu_req_out.vector == $past(ext_vec_in))
    else $error("external vector not used");
  a_encoded_top: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R3
    !irq_mode && !ext_fetch && ext_req_in == 4'hF && !nmi_in && !ubrk_in && !dbg_in
    && cpu_mask_in != 4'hF |=> cpu_req_out.level == 5'h0F && cpu_req_out.vector == 7'h47)
    else $error("encoded level 15 not presented");
  a_irq_level: assert property (@(posedge sys_clk_in) disable iff (!rstn_in) // R9
    irq_mode && win_found && win_idx == 4'(ivp_pkg::S_XIRQ+1) && !ext_fetch
    |=> cpu_req_out.vector == 7'h41 && cpu_req_out.level == {1'b0, $past(prio_c_r[11:8])})
    else $error("request pin 1 vector or level wrong");
endmodule : ivp_ctrl
`default_nettype wire

// *** verification/ivp_src_model.sv ***
// far-side model: on-chip request sources and the external vector supplier
`timescale 1ns/100ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module ivp_src_model (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic load_in,
  input wire logic [6:0] req_in,
  input wire logic [6:0] vec_in,
  output ivp_pkg::ivp_periph_t periph_out,
  output logic [6:0] ext_vec_out
);
  // sources hold their level until told otherwise; there is no acknowledge to wait for
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      periph_out <= '0;
      ext_vec_out <= 7'h00;
    end else if (load_in) begin
      periph_out <= req_in;
      ext_vec_out <= vec_in;
    end
  end
endmodule : ivp_src_model
`default_nettype wire

// *** verification/ivp_ctrl_tb.sv ***
// testbench: vector/priority map against a behavioural arbiter model
`timescale 1ns/100ps
`default_nettype none
module ivp_ctrl_tb;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic nmi_in = 1'b0;
  logic ubrk_in = 1'b0;
  logic dbg_in = 1'b0;
  logic [3:0] ext_req_in = 4'h0;
  logic [17:0] eth_set_in = 18'h0;
  logic [2:0] mac_status_in = 3'h0;
  logic [3:0] cpu_mask_in = 4'h0;
  logic ld = 1'b0;
  logic [6:0] sreq = 7'h00;
  logic [6:0] svec = 7'h00;
  logic [31:0] rdata_out;
  logic [31:0] vec_addr_out;
  logic eth_req_out;
  logic int_out;
  logic [6:0] ext_vec_in;
  ivp_pkg::ivp_periph_t periph_in;
  ivp_pkg::ivp_cpu_req_t cpu_req_out;
  ivp_pkg::ivp_cpu_req_t e;
  logic [31:0] mreg [0:11];
  integer seed = 93;
  int err_count = 0;
  int compares = 0;
  ////////////////////////////////////////////////////////////////////////////////
  ivp_src_model SRC (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .load_in(ld), .req_in(sreq),
    .vec_in(svec), .periph_out(periph_in), .ext_vec_out(ext_vec_in));
  ivp_ctrl DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .nmi_in(nmi_in),
    .ubrk_in(ubrk_in), .dbg_in(dbg_in), .ext_req_in(ext_req_in), .ext_vec_in(ext_vec_in),
    .periph_in(periph_in), .eth_set_in(eth_set_in), .mac_status_in(mac_status_in),
    .cpu_mask_in(cpu_mask_in), .cpu_req_out(cpu_req_out), .vec_addr_out(vec_addr_out),
    .eth_req_out(eth_req_out), .int_out(int_out));
  // free-running system clock
  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic close_out();
    if (err_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // one-cycle write, then an idle edge so back-to-back calls never re-drive the strobe in one step;
  // the mirror keeps only the bits that the register holds
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] m;
    m = (a == 8'h00) ? 32'h3 : (a == 8'h04) ? 32'hFFFF_FFFF : (a <= 8'h10) ? 32'hFFFF : 32'h7F7F;
    if (a <= 8'h2C)
      mreg[a[5:2]] = (a == 8'h24) ? 32'h0 : (d & m);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    @(posedge sys_clk_in);
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, exp);
    @(posedge sys_clk_in);
  endtask : rd_chk
  task automatic settle();
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask : settle
  // random programming of every register from offset 0x00 to 0x2C except the reserved slot
  task automatic prog();
    for (int a = 0; a <= 44; a += 4)
      if (a != 36)
        wr(8'(a), 32'($random(seed)));
  endtask : prog
  ////////////////////////////////////////////////////////////////////////////////
  // reference arbiter: slot order is the tie-break, strict compare keeps the earlier slot
  function automatic ivp_pkg::ivp_cpu_req_t model_req();
    int lv[15];
    int vc[15];
    logic ac[15];
    int b;
    int best;
    for (int i = 0; i < 15; i++) begin
      ac[i] = 1'b0;
      lv[i] = (i == 0) ? 16 : 15;
      vc[i] = 11 + i;
    end
    ac[0] = nmi_in;
    ac[1] = ubrk_in;
    ac[2] = dbg_in;
    for (int j = 0; j < 4; j++) begin
      ac[3 + j] = mreg[0][0] ? ext_req_in[j] : (j == 0 && ext_req_in != 4'h0);
      lv[3 + j] = mreg[0][0] ? mreg[4][15 - 4 * j -: 4] : ext_req_in;
      vc[3 + j] = mreg[0][1] ? svec : mreg[0][0] ? 64 + j : 64 + ext_req_in[3:1];
    end
    ac[7] = sreq[5];
    ac[8] = sreq[6];
    ac[9] = sreq[4];
    ac[10] = sreq[3];
    lv[7] = mreg[2][11:8];
    lv[8] = mreg[2][11:8];
    lv[9] = mreg[2][7:4];
    lv[10] = mreg[2][7:4];
    vc[7] = mreg[5][6:0];
    vc[8] = mreg[6][6:0];
    vc[9] = mreg[7][14:8];
    vc[10] = mreg[7][6:0];
    for (int k = 0; k < 3; k++) begin
      ac[12 + k] = sreq[k];
      lv[12 + k] = mreg[3][11:8];
    end
    vc[12] = mreg[10][14:8];
    vc[13] = mreg[10][6:0];
    vc[14] = mreg[11][14:8];
    b = -1;
    best = 0;
    for (int i = 0; i < 15; i++)
      if (ac[i] === 1'b1 && lv[i] > cpu_mask_in && lv[i] > best) begin
        b = i;
        best = lv[i];
      end
    return (b >= 0) ? {1'b1, 5'(best), 7'(vc[b])} : 13'h0000;
  endfunction : model_req
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole sequence needs about thirteen hundred cycles, the limit is 10000
  initial begin
    #100000;
    err_count++;
    close_out();
  end
  // main sequence
  initial begin
    foreach (mreg[i]) mreg[i] = 32'h0;
    repeat (4) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    @(posedge sys_clk_in);
    for (int a = 0; a <= 72; a += 4)
      rd_chk(8'(a), 32'h0);
    wr(8'h24, 32'hFFFF_FFFF);
    rd_chk(8'h24, 32'h0);
    wr(8'h48, 32'hFFFF_FFFF);
    rd_chk(8'h48, 32'h0);
    prog();
    rd_chk(8'h1C, mreg[7]);
    rd_chk(8'h28, mreg[10]);
    rd_chk(8'h04, mreg[1]);
    rd_chk(8'h10, mreg[4]);
    rd_chk(8'h00, mreg[0]);
    // random requests against the model, registers reshuffled now and then
    for (int i = 0; i < 300; i++) begin
      if (i % 25 == 0)
        prog();
      nmi_in <= (($random(seed) & 7) == 0);
      {ubrk_in, dbg_in, ext_req_in, cpu_mask_in} <= 10'($random(seed));
      {sreq, svec} <= 14'($random(seed));
      ld <= 1'b1;
      @(posedge sys_clk_in);
      ld <= 1'b0;
      @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      e = model_req();
      if (e.valid) begin
        chk({19'h0, cpu_req_out}, {19'h0, e});
        chk(vec_addr_out, mreg[1] + {23'h0, e.vector, 2'b00});
      end else
        chk({31'h0, cpu_req_out.valid}, 32'h0);
      @(posedge sys_clk_in);
    end
    nmi_in <= 1'b0;
    ubrk_in <= 1'b0;
    @(posedge sys_clk_in);
    // ethernet merge: only permitted status bits raise the combined request
    wr(8'h34, 32'h8);
    eth_set_in <= 18'h00028;
    @(posedge sys_clk_in);
    eth_set_in <= 18'h0;
    settle();
    chk({31'h0, eth_req_out}, 32'h1);
    @(posedge sys_clk_in);
    rd_chk(8'h30, 32'h28);
    wr(8'h30, 32'h8);
    settle();
    chk({31'h0, eth_req_out}, 32'h0);
    @(posedge sys_clk_in);
    wr(8'h34, 32'h0004_0000);
    wr(8'h38, 32'h2);
    mac_status_in <= 3'h2;
    settle();
    chk({31'h0, eth_req_out}, 32'h1);
    @(posedge sys_clk_in);
    mac_status_in <= 3'h1;
    wr(8'h30, 32'h0004_0000);
    settle();
    chk({31'h0, eth_req_out}, 32'h0);
    @(posedge sys_clk_in);
    // sticky event, enable mask and clear
    wr(8'h40, 32'h7);
    wr(8'h44, 32'h3);
    rd_chk(8'h3C, 32'h0);
    ubrk_in <= 1'b1;
    settle();
    chk({31'h0, int_out}, 32'h1);
    @(posedge sys_clk_in);
    rd_chk(8'h3C, 32'h2);
    wr(8'h44, 32'h1);
    settle();
    chk({31'h0, int_out}, 32'h0);
    @(posedge sys_clk_in);
    wr(8'h40, 32'h2);
    wr(8'h44, 32'h3);
    rd_chk(8'h3C, 32'h0);
    settle();
    chk({31'h0, int_out}, 32'h0);
    // a rise and a clear on the same edge: the set must win
    @(posedge sys_clk_in);
    ubrk_in <= 1'b0;
    @(posedge sys_clk_in);
    ubrk_in <= 1'b1;
    wr(8'h40, 32'h2);
    rd_chk(8'h3C, 32'h2);
    settle();
    chk({31'h0, int_out}, 32'h1);
    close_out();
  end
endmodule : ivp_ctrl_tb
`default_nettype wire
